// ===== pin_sync3.sv
`timescale 1ns/10ps
`default_nettype none

module pin_sync3 #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out
);

    logic meta_reg;
    logic stage2_reg;
    logic stage3_reg;

    // The first stage feeds only the second; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg   <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
            level_out  <= RESET_VAL;
        end else begin
            meta_reg   <= pin_in;
            stage2_reg <= meta_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level_out <= stage3_reg;
            end
        end
    end

endmodule

`default_nettype wire

// ===== window_timer_and_clock_monitor.sv
// Summary of operation
// - Reset holds both the window checker and clock monitor inactive.
// - After reset both are armed with the longest window selected.
// - Only the first valid service write after reset latches window and monitor choice.
// - First service write is valid only with the fixed key, else error.
// - Later writes must match stored window, fixed key and stored monitor bit.
// - A fully matching write inside the window is a valid service and restarts the count.
// - Any field mismatch in a service write raises the fault output.
// - Reading the service register returns zeros in the key bits.
// - Window error detection is suspended in HALT and IDLE.
// - Clock monitor stays active in HALT and IDLE.
// - RC option with startup delay clear resumes the window after HALT.
// - Otherwise HALT exit restarts the window; software waits 2048 cycles.
// - The idle counter is never cleared or loaded by reset.
// - Pending flag sets when idle counter bit 12 toggles; software clears it.
// - Leaving IDLE is an automatic service; software waits 2048 cycles.
// - First service is accepted anywhere in the 65536-cycle window.
// - Register bits 7:6 window select, 5:1 key, 0 monitor enable.
// - Select codes give 8k, 16k, 32k, 64k upper limits, 2048 lower.
// - Service before the lower limit or missing the upper limit is an error.
// - Fault pin driven low, held 16 cycles after sensed low and while a clock error lasts, then released.
`include "window_timer_params.svh"
`timescale 1ns/10ps
`default_nettype none

module window_timer_and_clock_monitor #(
    parameter int unsigned CLKMON_CYCLES = `CLKMON_LIMIT_US * 1000 / `CLK_PERIOD_NS
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        instr_tick_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out,
    input  wire logic        halt_in,
    input  wire logic        idle_in,
    input  wire logic        rc_osc_option_in,
    input  wire logic        oscillator_startup_delay_bit_in,
    input  wire logic        osc_sense_in,
    input  wire logic        fault_pin_in,
    output logic             fault_output_pin_out,
    output logic             fault_output_pin_oe_out,
    output logic             clock_fail_out,
    input  wire logic        idle_pend_clear_in,
    output logic             idle_tick_pending_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    window_timer_pkg::fault_state_t state_reg;
    window_timer_pkg::fault_state_t state_next;

    logic [1:0]  sel_reg;
    logic        mon_en_reg;
    logic        first_done_reg;
    logic [16:0] win_cnt_reg;
    logic [16:0] win_cnt_inc;
    logic [16:0] win_limit;
    logic [4:0]  hold_cnt_reg;
    logic [23:0] mon_cnt_reg;
    logic        osc_prev_reg;
    logic        halt_prev_reg;
    logic        idle_prev_reg;
    logic [15:0] idle_cnt_reg = 16'h0000;
    logic        idle_pend_reg;

    logic        osc_level;
    logic        pin_level;
    logic        svc_wr;
    logic        svc_rd;
    logic        accept;
    logic        key_ok;
    logic        fields_ok;
    logic        too_early;
    logic        svc_ok;
    logic        svc_err;
    logic        running;
    logic        timeout_err;
    logic        halt_exit;
    logic        idle_exit;
    logic        halt_restart;
    logic        halt_resume;
    logic        release_done;
    logic        win_restart;
    logic        clk_err;
    logic        any_err;
    logic        hold_done;
    logic        osc_edge;
    logic        idle_toggle;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pin_sync3 #(
        .RESET_VAL (1'b0)
    ) u_osc_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .pin_in     (osc_sense_in),
        .level_out  (osc_level)
    );

    pin_sync3 #(
        .RESET_VAL (1'b1)
    ) u_fault_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .pin_in     (fault_pin_in),
        .level_out  (pin_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Service write decode

    assign svc_wr    = wr_en_in && (addr_in == `SVC_ADDR);
    assign svc_rd    = rd_en_in && (addr_in == `SVC_ADDR);
    // A service while the fault pin is active is ignored
    assign accept    = svc_wr && (state_reg == window_timer_pkg::FLT_RUN);
    assign key_ok    = (wdata_in[`KEY_MSB:`KEY_LSB] == `SVC_KEY);
    assign fields_ok = key_ok && (!first_done_reg ||
                       ((wdata_in[`SEL_MSB:`SEL_LSB] == sel_reg) &&
                        (wdata_in[`MON_BIT] == mon_en_reg)));
    // no lower limit before the first service
    assign too_early = first_done_reg && (win_cnt_reg < `LOWER_LIMIT);
    assign svc_ok    = accept && fields_ok && !too_early;
    assign svc_err   = accept && (!fields_ok || too_early);

    ////////////////////////////////////////////////////////////////////////////////
    // Latched choices

    // reset arms the longest window with the monitor on
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_reg        <= `SEL_RESET;
            mon_en_reg     <= `MON_RESET;
            first_done_reg <= 1'b0;
        // one irrevocable latch of the choices
        end else if (accept && !first_done_reg && key_ok) begin
            sel_reg        <= wdata_in[`SEL_MSB:`SEL_LSB];
            mon_en_reg     <= wdata_in[`MON_BIT];
            first_done_reg <= 1'b1;
        end
    end

    // key bits always read back as zero
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (svc_rd) begin
            rdata_out <= {sel_reg, `KEY_READ_VALUE, mon_en_reg};
        end else begin
            rdata_out <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Low-power mode tracking

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            halt_prev_reg <= 1'b0;
            idle_prev_reg <= 1'b0;
        end else begin
            halt_prev_reg <= halt_in;
            idle_prev_reg <= idle_in;
        end
    end

    assign halt_exit    = halt_prev_reg && !halt_in;
    assign idle_exit    = idle_prev_reg && !idle_in;
    // RC oscillator without startup delay keeps the count
    assign halt_resume  = halt_exit && rc_osc_option_in && !oscillator_startup_delay_bit_in;
    // any other oscillator setup restarts the window
    assign halt_restart = halt_exit && !halt_resume;

    ////////////////////////////////////////////////////////////////////////////////
    // Service window counter

    // counting and timeout checks stop in HALT and IDLE
    assign running     = (state_reg == window_timer_pkg::FLT_RUN) && !halt_in && !idle_in;
    assign win_cnt_inc = win_cnt_reg + 17'h00001;
    // upper limit doubles with each select code
    assign win_limit   = first_done_reg ? (`UPPER_BASE << sel_reg) : `FIRST_LIMIT;
    assign timeout_err = running && instr_tick_in && (win_cnt_inc >= win_limit);
    assign release_done = (state_reg == window_timer_pkg::FLT_RELEASE) && pin_level;
    // leaving IDLE acts as a hardware service
    assign win_restart = svc_ok || idle_exit || halt_restart || release_done;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            win_cnt_reg <= 17'h00000;
        end else if (win_restart) begin
            win_cnt_reg <= 17'h00000;
        end else if (running && instr_tick_in && !timeout_err) begin
            win_cnt_reg <= win_cnt_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock monitor

    assign osc_edge = osc_level != osc_prev_reg;

    // runs regardless of HALT and IDLE, on the system clock
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_prev_reg <= 1'b0;
            mon_cnt_reg  <= 24'h000000;
        end else begin
            osc_prev_reg <= osc_level;
            if (osc_edge) begin
                mon_cnt_reg <= 24'h000000;
            end else if (mon_cnt_reg < CLKMON_CYCLES[23:0]) begin
                mon_cnt_reg <= mon_cnt_reg + 24'h000001;
            end
        end
    end

    // Slow clocks between the two bounds may or may not be rejected; the gap is a parameter
    assign clk_err        = mon_en_reg && (mon_cnt_reg >= CLKMON_CYCLES[23:0]);
    assign clock_fail_out = clk_err;

    ////////////////////////////////////////////////////////////////////////////////
    // Fault pin sequencing

    assign any_err   = svc_err || timeout_err || clk_err;
    assign hold_done = (hold_cnt_reg == `HOLD_CYCLES) && !clk_err;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            window_timer_pkg::FLT_RUN: begin
                if (any_err) begin
                    state_next = window_timer_pkg::FLT_DRIVE;
                end
            end
            window_timer_pkg::FLT_DRIVE: begin
                if (!pin_level) begin
                    state_next = window_timer_pkg::FLT_HOLD;
                end
            end
            window_timer_pkg::FLT_HOLD: begin
                if (hold_done) begin
                    state_next = window_timer_pkg::FLT_RELEASE;
                end
            end
            window_timer_pkg::FLT_RELEASE: begin
                if (pin_level) begin
                    state_next = window_timer_pkg::FLT_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= window_timer_pkg::FLT_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // count ticks once the pin is seen low
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hold_cnt_reg <= 5'h00;
        end else if (state_reg != window_timer_pkg::FLT_HOLD) begin
            hold_cnt_reg <= 5'h00;
        end else if (instr_tick_in && (hold_cnt_reg != `HOLD_CYCLES)) begin
            hold_cnt_reg <= hold_cnt_reg + 5'h01;
        end
    end

    // Open drain: only ever pulls low
    assign fault_output_pin_out    = 1'b0;
    assign fault_output_pin_oe_out = (state_reg == window_timer_pkg::FLT_DRIVE) ||
                                     (state_reg == window_timer_pkg::FLT_HOLD);

    ////////////////////////////////////////////////////////////////////////////////
    // Idle interval counter

    // deliberately free of reset, so the phase survives a reset
    always_ff @(posedge sys_clk_in) begin
        if (instr_tick_in) begin
            idle_cnt_reg <= idle_cnt_reg + 16'h0001;
        end
    end

    assign idle_toggle = instr_tick_in && (idle_cnt_reg[`IDLE_TOGGLE_BIT-1:0] == 12'hFFF);

    // set wins over a simultaneous clear
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_pend_reg <= 1'b0;
        end else if (idle_toggle) begin
            idle_pend_reg <= 1'b1;
        end else if (idle_pend_clear_in) begin
            idle_pend_reg <= 1'b0;
        end
    end

    assign idle_tick_pending_out = idle_pend_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_reset_defaults: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !first_done_reg |-> (sel_reg == 2'h3) && mon_en_reg)
        else $error("choices changed before first valid service");

    a_choices_locked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        first_done_reg && svc_wr |=> $stable(sel_reg) && $stable(mon_en_reg))
        else $error("latched choices changed after first service");

    a_first_bad_key: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        accept && !first_done_reg && !key_ok |=> fault_output_pin_oe_out)
        else $error("bad first key did not drive fault");

    a_field_mismatch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        accept && first_done_reg && (wdata_in[`MON_BIT] != mon_en_reg)
        |=> fault_output_pin_oe_out)
        else $error("monitor field mismatch not flagged");

    a_valid_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        svc_ok |=> (win_cnt_reg == 17'h00000) && !fault_output_pin_oe_out)
        else $error("valid service did not restart window");

    a_key_reads_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        svc_rd |=> (rdata_out[5:1] == 5'h00) && (rdata_out[7:6] == $past(sel_reg)))
        else $error("service read exposed key or lost select");

    a_mode_freeze: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (halt_in || idle_in) && !svc_wr && (state_reg == window_timer_pkg::FLT_RUN)
        |=> $stable(win_cnt_reg))
        else $error("window count moved in low power mode");

    a_halt_resume: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        halt_resume && !idle_exit && !idle_in && !svc_wr && instr_tick_in && !timeout_err &&
        (state_reg == window_timer_pkg::FLT_RUN)
        |=> win_cnt_reg == $past(win_cnt_reg) + 17'h00001)
        else $error("window did not resume after halt");

    a_idle_service: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        idle_exit |=> win_cnt_reg == 17'h00000)
        else $error("idle exit did not restart window");

    a_clkmon_active: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        clk_err && (state_reg == window_timer_pkg::FLT_RUN) |=> fault_output_pin_oe_out)
        else $error("clock error did not drive fault");

    a_early_service: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        accept && first_done_reg && (win_cnt_reg < 17'h00800) |=> fault_output_pin_oe_out)
        else $error("early service not flagged");

    a_pending_set: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        idle_toggle |=> idle_tick_pending_out)
        else $error("idle toggle did not set pending");

    a_hold_length: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (state_reg == window_timer_pkg::FLT_HOLD) && (hold_cnt_reg < 5'h10)
        |=> fault_output_pin_oe_out)
        else $error("fault pin released before hold time");

endmodule

`default_nettype wire

// ===== window_timer_and_clock_monitor_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "window_timer_params.svh"

module window_timer_and_clock_monitor_tb;

    localparam int unsigned MON_CYCLES = 50;

    logic        sys_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic        tick      = 1'b1;
    logic [15:0] addr      = 16'h0000;
    logic        wr_en     = 1'b0;
    logic        rd_en     = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic [7:0]  rdata;
    logic        halt      = 1'b0;
    logic        idle      = 1'b0;
    logic        rc_opt    = 1'b0;
    logic        dly_bit   = 1'b0;
    logic        osc       = 1'b0;
    logic        osc_run   = 1'b1;
    logic [1:0]  osc_div   = 2'h0;
    logic        fault_pin = 1'b1;
    logic        flt_out;
    logic        flt_oe;
    logic        clk_fail;
    logic        pend_clr  = 1'b0;
    logic        pend;
    logic [31:0] rnd       = 32'hE974;
    logic [4:0]  key;
    int          n_errors  = 0;
    int          n_checks  = 0;
    int          m_sel;
    int          m_mon;
    int          m_first;
    int          m_cnt;
    int          wt;

    window_timer_and_clock_monitor #(
        .CLKMON_CYCLES(MON_CYCLES)
    ) i_dut (
        .sys_clk_in                     (sys_clk),
        .rst_in                         (rst),
        .instr_tick_in                  (tick),
        .addr_in                        (addr),
        .wr_en_in                       (wr_en),
        .rd_en_in                       (rd_en),
        .wdata_in                       (wdata),
        .rdata_out                      (rdata),
        .halt_in                        (halt),
        .idle_in                        (idle),
        .rc_osc_option_in               (rc_opt),
        .oscillator_startup_delay_bit_in(dly_bit),
        .osc_sense_in                   (osc),
        .fault_pin_in                   (fault_pin),
        .fault_output_pin_out           (flt_out),
        .fault_output_pin_oe_out        (flt_oe),
        .clock_fail_out                 (clk_fail),
        .idle_pend_clear_in             (pend_clr),
        .idle_tick_pending_out          (pend)
    );

    always #5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Pull-up on the fault pin: it reads low only while the block pulls it
    always @(negedge sys_clk) begin
        rnd       <= lfsr_next(rnd);
        osc_div   <= osc_div + 2'h1;
        fault_pin <= ~flt_oe;
        pend_clr  <= rnd[5] & rnd[9];
        if (osc_run && osc_div == 2'h0) begin
            osc <= ~osc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Model window count only advances outside the low-power modes
    task automatic cyc(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            if (!halt && !idle) begin
                m_cnt++;
            end
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        cyc(6);
        check({6'h00, flt_oe, clk_fail}, 8'h00);
        rst     = 1'b0;
        m_sel   = 3;
        m_mon   = 1;
        m_first = 0;
        m_cnt   = 0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        addr  = a;
        rd_en = 1'b1;
        cyc(1);
        rd_en = 1'b0;
        check(rdata, exp);
    endtask

    task automatic recover();
        int n;
        n = 0;
        check({7'h00, flt_out}, 8'h00);
        while (flt_oe === 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        check({7'h00, n >= 17 && n <= 40}, 8'h01);
        cyc(12);
        m_cnt = 0;
    endtask

    // Expected outcome worked out from the model before the write is made
    task automatic svc(input logic [7:0] d);
        logic err;
        if (m_first == 0) begin
            err = (d[5:1] !== `SVC_KEY);
        end else begin
            err = (d[5:1] !== `SVC_KEY) || (int'(d[7:6]) != m_sel)
                || (int'(d[0]) != m_mon) || (m_cnt < 2048);
        end
        addr  = `SVC_ADDR;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        cyc(1);
        check({7'h00, flt_oe}, {7'h00, err});
        if (err) begin
            recover();
        end else begin
            if (m_first == 0) begin
                m_sel = d[7:6];
                m_mon = d[0];
            end
            m_first = 1;
            m_cnt   = 0;
        end
    endtask

    task automatic tmo(input int lim);
        int n;
        n = 0;
        while (flt_oe !== 1'b1 && n < lim + 50) begin
            cyc(1);
            n++;
        end
        check({7'h00, n > lim - 8 && n < lim + 8}, 8'h01);
        recover();
    endtask

    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        rd(`SVC_ADDR, 8'hC1);
        addr  = 16'h00C6;
        wdata = rnd[7:0];
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
        cyc(2);
        check({7'h00, flt_oe}, 8'h00);
        rd(16'h00C6, 8'h00);
        rd(`SVC_ADDR, 8'hC1);
        $display("test reset_values done");

        key = rnd[5:1];
        if (key == `SVC_KEY) begin
            key = ~key;
        end
        svc({2'b00, key, 1'b1});
        cyc(1000);
        svc(8'h19);
        rd(`SVC_ADDR, 8'h01);
        cyc(2500);
        svc(8'h59);
        rd(`SVC_ADDR, 8'h01);
        cyc(2500);
        svc(8'h18);
        cyc(2200 + int'(rnd[9:0]));
        svc(8'h19);
        cyc(1000);
        svc(8'h19);
        $display("test service_fields done");

        for (int s = 0; s < 4; s++) begin
            do_reset();
            cyc(int'(rnd[7:0]));
            svc({s[1:0], `SVC_KEY, 1'b0});
            rd(`SVC_ADDR, {s[1:0], 6'h00});
            if (s < 2) begin
                tmo(8192 << s);
            end else begin
                osc_run = 1'b0;
                cyc(MON_CYCLES * 3);
                check({7'h00, clk_fail}, 8'h00);
                osc_run = 1'b1;
            end
        end
        $display("test window_select done");

        // Crystal restarts, RC with delay clear resumes, RC with delay set restarts
        for (int m = 0; m < 3; m++) begin
            rc_opt  = (m != 0);
            dly_bit = (m == 2);
            do_reset();
            svc(8'h19);
            cyc(5000);
            halt = 1'b1;
            cyc(4000);
            check({7'h00, flt_oe}, 8'h00);
            halt = 1'b0;
            if (m != 1) begin
                m_cnt = 0;
            end
            cyc(1000);
            svc(8'h19);
        end
        $display("test halt_exit done");

        do_reset();
        svc(8'h19);
        cyc(5000);
        idle = 1'b1;
        cyc(4000);
        check({7'h00, flt_oe}, 8'h00);
        idle  = 1'b0;
        m_cnt = 0;
        cyc(1000);
        svc(8'h19);
        $display("test idle_exit done");

        do_reset();
        halt    = 1'b1;
        osc_run = 1'b0;
        wt      = 0;
        while (clk_fail !== 1'b1 && wt < 200) begin
            cyc(1);
            wt++;
        end
        cyc(2);
        check({6'h00, clk_fail, flt_oe}, 8'h03);
        check({7'h00, wt >= 40}, 8'h01);
        osc_run = 1'b1;
        halt    = 1'b0;
        wt      = 0;
        while (flt_oe === 1'b1 && wt < 400) begin
            cyc(1);
            wt++;
        end
        check({6'h00, clk_fail, flt_oe}, 8'h00);
        $display("test clock_monitor done");

        // Pending flag must be seen within one 4096-cycle idle period
        wt = 0;
        while (pend !== 1'b1 && wt < 4200) begin
            cyc(1);
            wt++;
        end
        check({7'h00, pend}, 8'h01);
        check({7'h00, wt <= 4097}, 8'h01);
        $display("test idle_pending done");
        results();
    end

    // Runs take about 0.8 ms; this 0.95 ms limit leaves some margin
    initial begin
        #950_000;
        n_errors++;
        results();
    end

endmodule

`default_nettype wire

// ===== window_timer_params.svh
`ifndef WINDOW_TIMER_PARAMS_SVH
`define WINDOW_TIMER_PARAMS_SVH

// Service register location and field layout
`define SVC_ADDR          16'h00C7
`define SEL_MSB           7
`define SEL_LSB           6
`define KEY_MSB           5
`define KEY_LSB           1
`define MON_BIT           0
`define SVC_KEY           5'h0C
`define KEY_READ_VALUE    5'h00

// Reset values of the latched choices
`define SEL_RESET         2'h3
`define MON_RESET         1'b1

// Service window limits, in instruction cycles
`define LOWER_LIMIT       17'h00800
`define UPPER_BASE        17'h02000
`define FIRST_LIMIT       17'h10000

// Fault pin hold time after the pin is sensed low, in instruction cycles
`define HOLD_CYCLES       5'h10

// Idle counter bit whose toggle sets the pending flag
`define IDLE_TOGGLE_BIT   12

// Clock monitor: longest gap between oscillator edges before rejection
`define CLK_PERIOD_NS     10
`define CLKMON_LIMIT_US   100000

`endif

// ===== window_timer_pkg.sv
package window_timer_pkg;

    typedef enum logic [3:0] {
        FLT_RUN     = 4'b0001,
        FLT_DRIVE   = 4'b0010,
        FLT_HOLD    = 4'b0100,
        FLT_RELEASE = 4'b1000
    } fault_state_t;

endpackage
